// [address_decode_page_mapper_test.sv]
// Self-checking testbench of the address decoder and page mapper.
`timescale 1ns/1ps
`default_nettype none
module address_decode_page_mapper_test;
  import apm_pkg::*;
  logic core_clk, arst_n, base_clk_15m, as_n, uds_n, lds_n, rd, fc2, remap, want;
  logic [23:1] addr;
  logic [15:0] wdata, map_rdata_r, r_data;
  logic [2:0]  ctx, r_sel, r_aux;
  logic [21:0] phys_addr_r, r_pa;
  logic dtack_n, berr_n, viol_n, oe_n, ram_sel, rom_sel, io_sel, buf_en, grant_n;
  logic req_n, ras0_n, ras1_n, div2, div4_n, div8_n, div16_n, str_n, r_berr;
  int n_fail = 0, check_count = 0, cyc_n = 0, n2, n4, n8, n16, ns;

  apm_mapper DUT (.core_clk(core_clk), .arst_n(arst_n), .base_clk_15m(base_clk_15m),
    .cpu_addr(addr), .cpu_wdata(wdata), .cpu_as_n(as_n), .cpu_uds_n(uds_n),
    .cpu_lds_n(lds_n), .cpu_rd(rd), .cpu_fc2(fc2), .ctrl_context(ctx),
    .ram_ras0_n(ras0_n), .ram_ras1_n(ras1_n), .disk_ram_request_n(req_n),
    .boot_rom_remap(remap), .cpu_dtack_n_r(dtack_n), .cpu_berr_n_r(berr_n),
    .violation_async_n(viol_n), .map_rdata_r(map_rdata_r), .map_rdata_oe_n_r(oe_n),
    .ram_sel_r(ram_sel), .rom_sel_r(rom_sel), .io_sel_r(io_sel), .ram_buf_en_r(buf_en),
    .phys_addr_r(phys_addr_r), .disk_grant_n_r(grant_n), .cpu_clk_div2(div2),
    .phase_clk_div4_n(div4_n), .clk_div8_n(div8_n), .clk_div16_n(div16_n),
    .stretched_clk_n(str_n));
  apm_disk_model partner (.core_clk(core_clk), .want(want), .grant_n(grant_n),
    .ram_sel(ram_sel), .req_n(req_n), .ras0_n(ras0_n), .ras1_n(ras1_n));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    base_clk_15m = 1'b0;
    forever #31.91 base_clk_15m = ~base_clk_15m;
  end
  always @(posedge div2) n2++;
  always @(negedge div4_n) n4++;
  always @(negedge div8_n) n8++;
  always @(negedge div16_n) n16++;
  always @(negedge str_n) ns++;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      n_fail++;
      conclude;
    end
  end

  task automatic bus_go(input logic [23:0] a, input logic wr, input logic [15:0] wd,
                        input logic sup);
    @(posedge core_clk);
    #2;
    addr = a[23:1];
    wdata = wd;
    rd = ~wr;
    fc2 = sup;
    as_n = 1'b0;
  endtask

  // Waits for acknowledge or bus error, captures the answer, then ends the cycle.
  task automatic bus_done;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (dtack_n !== 1'b0 && berr_n !== 1'b0 && n < 60);
    check("answer", n < 60, 1'b1);
    r_data = map_rdata_r;
    r_berr = ~berr_n;
    r_pa = phys_addr_r;
    r_sel = {ram_sel, rom_sel, io_sel};
    r_aux = {buf_en, ~oe_n, ~viol_n};
    @(posedge core_clk);
    #2;
    as_n = 1'b1;
    n = 0;
    while ((dtack_n !== 1'b1 || berr_n !== 1'b1) && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask

  task automatic cyc(input logic [23:0] a, input logic wr, input logic [15:0] wd,
                     input logic sup);
    bus_go(a, wr, wd, sup);
    bus_done;
  endtask

  // Boot fetch: ROM at zero while the boot_rom_remap is high; firmware then clears it.
  task automatic t_remap;
    cyc(24'h000100, 1'b0, 16'h0000, 1'b1);
    check("rom_at_zero", r_sel, 3'b010);
    #2 remap = 1'b0;
  endtask

  // Entries are stored with byte strobes idle and read back whole.
  task automatic t_map;
    uds_n = 1'b1;
    lds_n = 1'b1;
    ctx = 3'h0;
    cyc(24'h800000 + 24'h000800 * 5, 1'b1, 16'h3123, 1'b1);
    ctx = 3'h3;
    cyc(24'h800000 + 24'h000800 * 5, 1'b1, 16'h0456, 1'b1);
    cyc(24'h800000 + 24'h000800 * 7, 1'b1, 16'h8011, 1'b1);
    cyc(24'h800000 + 24'h000800 * 8, 1'b1, 16'h4022, 1'b1);
    cyc(24'h800000 + 24'h000800 * 5, 1'b0, 16'h0000, 1'b1);
    check("map_read", r_data, 16'h0456);
    check("map_read_pins", r_aux, 3'b010);
    uds_n = 1'b0;
    lds_n = 1'b0;
    ctx = 3'h0;
    cyc(24'h800000 + 24'h000800 * 5, 1'b0, 16'h0000, 1'b1);
    check("map_ctx0", r_data, 16'h3123);
  endtask

  // Supervisor uses context zero whatever the register holds; user uses the register.
  task automatic t_ram;
    ctx = 3'h3;
    cyc(24'h000000 + 24'h000800 * 5 + 24'h0002A6, 1'b0, 16'h0000, 1'b1);
    check("sup_phys", r_pa, {12'h123, 10'h153});
    check("sup_sel", r_sel, 3'b100);
    check("ram_buf", r_aux, 3'b100);
    cyc(24'h000800 * 5 + 24'h0007FE, 1'b0, 16'h0000, 1'b0);
    check("user_phys", r_pa, {12'h456, 10'h3FF});
    check("user_ok", r_berr, 1'b0);
  endtask

  // Protection bits and supervisor-only sections in user state.
  task automatic t_user;
    cyc(24'h000800 * 7, 1'b0, 16'h0000, 1'b0);
    check("fault_read", r_berr, 1'b1);
    check("fault_viol", r_aux, 3'b001);
    cyc(24'h000800 * 8, 1'b1, 16'h1234, 1'b0);
    check("wprot_write", r_berr, 1'b1);
    cyc(24'h000800 * 8, 1'b0, 16'h0000, 1'b0);
    check("wprot_read", r_berr, 1'b0);
    cyc(24'h800000 + 24'h000800 * 5, 1'b1, 16'hFFFF, 1'b0);
    check("user_map", r_berr, 1'b1);
    check("user_map_viol", r_aux, 3'b001);
    cyc(24'hC00010, 1'b0, 16'h0000, 1'b0);
    check("user_io", r_berr, 1'b1);
    cyc(24'h800000 + 24'h000800 * 5, 1'b0, 16'h0000, 1'b1);
    check("map_unchanged", r_data, 16'h0456);
    cyc(24'hC00010, 1'b0, 16'h0000, 1'b1);
    check("sup_io", {r_berr, r_sel}, 4'b0001);
    cyc(24'h40FFFE, 1'b0, 16'h0000, 1'b1);
    check("rom_sel", r_sel, 3'b010);
  endtask

  // A processor RAM cycle waits while the disk owns RAM; other targets stay open.
  task automatic t_disk;
    int n;
    want = 1'b1;
    n = 0;
    while (grant_n !== 1'b0 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("grant", grant_n, 1'b0);
    cyc(24'h400010, 1'b0, 16'h0000, 1'b1);
    check("rom_in_dma", r_sel, 3'b010);
    bus_go(24'h000800 * 5, 1'b0, 16'h0000, 1'b1);
    repeat (20) @(posedge core_clk);
    #1;
    check("held_dtack", dtack_n, 1'b1);
    check("buf_isolated", buf_en, 1'b0);
    want = 1'b0;
    bus_done;
    check("after_dma", {r_sel, r_pa[21:10]}, {3'b100, 12'h123});
    check("buf_after_dma", r_aux, 3'b100);
  endtask

  // Divider ratios and the stretched clock's 17-to-4 average against base periods.
  task automatic t_clks;
    n2 = 0;
    n4 = 0;
    n8 = 0;
    n16 = 0;
    ns = 0;
    repeat (15000) @(posedge core_clk);
    check("div4", n2 >= 2 * n4 - 2 && n2 <= 2 * n4 + 2, 1'b1);
    check("div8", n2 >= 4 * n8 - 4 && n2 <= 4 * n8 + 4, 1'b1);
    check("div16", n2 >= 8 * n16 - 8 && n2 <= 8 * n16 + 8, 1'b1);
    check("stretch", 17 * ns >= 8 * n2 - 34 && 17 * ns <= 8 * n2 + 34, 1'b1);
  endtask

  // The bench never issues an indivisible read-modify-write cycle.
  initial begin
    arst_n = 1'b0;
    as_n = 1'b1;
    uds_n = 1'b0;
    lds_n = 1'b0;
    rd = 1'b1;
    fc2 = 1'b1;
    remap = 1'b1;
    want = 1'b0;
    addr = '0;
    wdata = '0;
    ctx = 3'h0;
    repeat (6) @(posedge core_clk);
    #2 arst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    t_remap;
    t_map;
    t_ram;
    t_user;
    t_disk;
    t_clks;
    conclude;
  end
endmodule // address_decode_page_mapper_test
`default_nettype wire

// [apm_clkgen.sv]
// Divided and stretched system clocks derived from the base clock edges.
`timescale 1ns/1ps
`default_nettype none
module apm_clkgen
  import apm_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      arst_n,
  input  wire logic      base_lvl,
  output var  apm_clks_t clks
);

  typedef struct packed {
    logic       prev;
    logic [3:0] cnt;
    logic [3:0] scnt;
    logic       hold;
    apm_clks_t  o;
  } apm_cg_st_t;

  apm_cg_st_t st_r;
  apm_cg_st_t st_nxt;
  logic       edge_seen;

  assign edge_seen = base_lvl && !st_r.prev;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = base_lvl;
    if (edge_seen) begin
      st_nxt.cnt = st_r.cnt + 4'h1;
      // One held base period after sixteen counts gives 17 base periods per 4.
      if (st_r.hold) begin
        st_nxt.hold = 1'b0;
      end else begin
        st_nxt.scnt = st_r.scnt + 4'h1;
        if (st_r.scnt == STRETCH_COUNT) begin
          st_nxt.hold = 1'b1;
        end
      end
    end
    st_nxt.o.div2        = st_nxt.cnt[0];
    st_nxt.o.div4_n      = !st_nxt.cnt[1];
    st_nxt.o.div8_n      = !st_nxt.cnt[2];
    st_nxt.o.div16_n     = !st_nxt.cnt[3];
    st_nxt.o.stretched_n = st_nxt.scnt[1];
    st_nxt.o.phase       = st_nxt.cnt[1:0];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{o: '{div4_n: 1'b1, div8_n: 1'b1, div16_n: 1'b1, default: '0},
                default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clks = st_r.o;

  a_div_phase: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(st_r.cnt) |-> st_r.o.div2 == st_r.cnt[0] && st_r.o.div4_n == !st_r.cnt[1])
    else $error("Divided clocks out of phase with the base count.");

endmodule // apm_clkgen
`default_nettype wire

// [apm_disk_model.sv]
// Disk requester and RAM row strobe model on the far side of the mapper.
`timescale 1ns/1ps
`default_nettype none
module apm_disk_model (
  input  wire logic core_clk,
  input  wire logic want,
  input  wire logic grant_n,
  input  wire logic ram_sel,
  output logic      req_n,
  output logic      ras0_n,
  output logic      ras1_n
);
  logic got_r;
  initial begin
    req_n = 1'b1;
    got_r = 1'b0;
  end
  // A request is held until granted, since a real disk cannot abandon a transfer.
  always @(posedge core_clk) begin
    if (!grant_n) got_r <= 1'b1;
    if (want) req_n <= 1'b0;
    else if (got_r || req_n) begin
      req_n <= 1'b1;
      got_r <= 1'b0;
    end
  end
  // The row strobe follows a processor RAM cycle; the second row stays idle.
  assign ras0_n = ~ram_sel;
  assign ras1_n = 1'b1;
endmodule // apm_disk_model
`default_nettype wire

// [apm_mapper.sv]
// Address decoder, per-context page mapper, protection and disk access arbiter.
// What this block does
// - Split 16 Mbyte space into RAM, ROM, map, I/O sections of 4 Mbytes.
// - RAM section is 2 Mbyte logical, 2 Kbyte pages, onto 8 Mbyte physical.
// - Second section selects the 64 Kbyte ROM.
// - Eight independent contexts, each with its own page table.
// - Supervisor translates with context zero; user with control register context.
// - Map and I/O sections are supervisor only; user access is a violation.
// - During disk access the RAM buffer isolates the processor from RAM.
// - Each context holds 1024 entries; pages may share physical pages.
// - Entry bit 15 fault, bit 14 write protect, bits 0-11 physical page.
// - User access to faulted page, or write to protected page, is a bus error.
// - Selected context entries appear in map section at logical address plus base.
// - Map accesses are whole words; byte strobes are ignored.
// - Base clock divided by 2, 4, 8 and 16 in fixed phase.
// - Stretched clock gains one base period every sixteen counts.
// - Disk grant needs request and no row strobe, changes on clock phase.
// - Boot remap high puts ROM in the lowest section; low restores RAM.
// - Function code bit 2 high is supervisor; low means protected user access.
// - Violation formed first, then resynchronised to bus cycle as bus error.
// - RAM context bits come from control register in user state, zero otherwise; map section always uses the register.
// - RAM cycle waits while disk holds RAM; a begun cycle finishes first.
`timescale 1ns/1ps
`default_nettype none
module apm_mapper
  import apm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        base_clk_15m,
  input  wire logic [23:1] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  input  wire logic        cpu_as_n,
  input  wire logic        cpu_uds_n,
  input  wire logic        cpu_lds_n,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_fc2,
  input  wire logic [2:0]  ctrl_context,
  input  wire logic        ram_ras0_n,
  input  wire logic        ram_ras1_n,
  input  wire logic        disk_ram_request_n,
  input  wire logic        boot_rom_remap,
  output logic             cpu_dtack_n_r,
  output logic             cpu_berr_n_r,
  output logic             violation_async_n,
  output logic [15:0]      map_rdata_r,
  output logic             map_rdata_oe_n_r,
  output logic             ram_sel_r,
  output logic             rom_sel_r,
  output logic             io_sel_r,
  output logic             ram_buf_en_r,
  output logic [22:1]      phys_addr_r,
  output logic             disk_grant_n_r,
  output logic             cpu_clk_div2,
  output logic             phase_clk_div4_n,
  output logic             clk_div8_n,
  output logic             clk_div16_n,
  output logic             stretched_clk_n
);

  typedef struct packed {
    apm_cyc_t    cyc;
    logic        dtack_n;
    logic        berr_n;
    logic        viol_n;
    logic [15:0] rdata;
    logic        rdata_oe_n;
    logic        ram_sel;
    logic        rom_sel;
    logic        io_sel;
    logic        buf_en;
    logic [22:1] paddr;
    logic        grant_n;
  } apm_top_st_t;

  apm_top_st_t st_r;
  apm_top_st_t st_nxt;
  apm_pins_t   pins_raw;
  apm_pins_t   bus;
  apm_clks_t   clks;

  // The page tables of all contexts; no reset, firmware loads them.
  logic [15:0] map_mem [NUM_CTX*NUM_PAGES];
  logic [15:0] entry_q;

  logic [1:0]          sec_raw;
  logic [1:0]          sec;
  logic                user;
  logic [CTX_W-1:0]    ctx_ram;
  logic [CTX_W+9:0]    ram_idx;
  logic [CTX_W+9:0]    map_idx;
  logic                map_we;
  logic                start;
  logic                phase_ok;
  logic                cpu_ram_busy;
  logic                entry_bad;
  logic [PAGE_LSB-1:1] offset_bits;

  assign pins_raw = '{data: cpu_wdata, addr: cpu_addr, as_n: cpu_as_n, uds_n: cpu_uds_n,
                      lds_n: cpu_lds_n, rd: cpu_rd, fc2: cpu_fc2, ras0_n: ram_ras0_n,
                      ras1_n: ram_ras1_n, dma_req_n: disk_ram_request_n,
                      remap: boot_rom_remap, base_clk: base_clk_15m};

  apm_sync u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pins_in  (pins_raw),
    .pins_out (bus)
  );

  apm_clkgen u_clkgen (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .base_lvl (bus.base_clk),
    .clks     (clks)
  );

  assign sec_raw = bus.addr[SEC_MSB:SEC_LSB];

  // The remap strap aliases ROM over RAM so the reset vector is fetched from ROM.
  assign sec = (sec_raw == SEC_RAM && bus.remap) ? SEC_ROM : sec_raw;

  assign user    = !bus.fc2;
  assign ctx_ram = user ? ctrl_context : CTX_SUPER;

  // Logical page index inside the 2 Mbyte space; addresses above it alias.
  assign ram_idx = {ctx_ram, bus.addr[PAGE_MSB:PAGE_LSB]};
  assign map_idx = {ctrl_context, bus.addr[PAGE_MSB:PAGE_LSB]};

  assign start = st_r.cyc == CYC_IDLE && !bus.as_n;

  // Offset bits kept apart so the translation check can look back at them.
  assign offset_bits = bus.addr[PAGE_LSB-1:1];

  // Byte strobes take no part, so a map write always stores the whole word.
  assign map_we = start && sec == SEC_MAP && !user && !bus.rd;

  always_ff @(posedge core_clk) begin
    if (map_we) begin
      map_mem[map_idx] <= bus.data;
    end
    entry_q <= map_mem[(sec == SEC_MAP) ? map_idx : ram_idx];
  end

  assign entry_bad = user && (entry_q[ENT_FAULT] || (entry_q[ENT_WPROT] && !bus.rd));

  assign phase_ok     = clks.phase == GRANT_PHASE;
  // A CPU RAM cycle counts as begun from the edge that takes it until it ends.
  assign cpu_ram_busy = st_r.ram_sel || st_r.cyc == CYC_LOOKUP || st_r.cyc == CYC_WAIT_DMA
                        || (start && sec == SEC_RAM);

  always_comb begin
    st_nxt = st_r;
    // Disk grant changes only on the agreed clock phase; a begun CPU cycle wins.
    if (phase_ok) begin
      if (st_r.grant_n && !bus.dma_req_n && bus.ras0_n && bus.ras1_n
          && !cpu_ram_busy) begin
        st_nxt.grant_n = 1'b0;
      end else if (!st_r.grant_n && bus.dma_req_n) begin
        st_nxt.grant_n = 1'b1;
      end
    end
    // The violation is raised first and only reaches the processor a cycle later.
    if (!st_r.viol_n && !bus.as_n) begin
      st_nxt.berr_n = 1'b0;
    end
    unique case (st_r.cyc)
      CYC_IDLE: begin
        if (!bus.as_n) begin
          unique case (sec)
            SEC_RAM: begin
              // While disk owns RAM the cycle is held with buffers off.
              st_nxt.cyc = st_r.grant_n ? CYC_LOOKUP : CYC_WAIT_DMA;
            end
            SEC_ROM: begin
              st_nxt.rom_sel = 1'b1;
              st_nxt.dtack_n = 1'b0;
              st_nxt.cyc     = CYC_END;
            end
            SEC_MAP: begin
              if (user) begin
                st_nxt.viol_n = 1'b0;
              end else begin
                st_nxt.cyc = CYC_LOOKUP;
              end
              st_nxt.cyc = user ? CYC_END : CYC_LOOKUP;
            end
            SEC_IO: begin
              if (user) begin
                st_nxt.viol_n = 1'b0;
              end else begin
                st_nxt.io_sel  = 1'b1;
                st_nxt.dtack_n = 1'b0;
              end
              st_nxt.cyc = CYC_END;
            end
          endcase
        end
      end
      CYC_WAIT_DMA: begin
        if (bus.as_n) begin
          st_nxt.cyc = CYC_IDLE;
        end else if (st_r.grant_n) begin
          st_nxt.cyc = CYC_LOOKUP;
        end
      end
      CYC_LOOKUP: begin
        if (sec == SEC_MAP) begin
          st_nxt.rdata      = entry_q;
          st_nxt.rdata_oe_n = !bus.rd;
          st_nxt.dtack_n    = 1'b0;
          st_nxt.cyc        = CYC_END;
        end else if (entry_bad) begin
          st_nxt.viol_n = 1'b0;
          st_nxt.cyc    = CYC_END;
        end else begin
          // Only the page number is replaced; the offset passes straight.
          st_nxt.paddr   = {entry_q[ENT_PHYS_MSB:0], bus.addr[PAGE_LSB-1:1]};
          st_nxt.ram_sel = 1'b1;
          st_nxt.buf_en  = 1'b1;
          st_nxt.dtack_n = 1'b0;
          st_nxt.cyc     = CYC_ACK;
        end
      end
      CYC_ACK, CYC_END: begin
        if (bus.as_n) begin
          st_nxt.cyc        = CYC_IDLE;
          st_nxt.dtack_n    = 1'b1;
          st_nxt.berr_n     = 1'b1;
          st_nxt.viol_n     = 1'b1;
          st_nxt.rdata_oe_n = 1'b1;
          st_nxt.ram_sel    = 1'b0;
          st_nxt.rom_sel    = 1'b0;
          st_nxt.io_sel     = 1'b0;
          st_nxt.buf_en     = 1'b0;
        end
      end
    endcase
    // The RAM buffer never joins the buses while the disk holds RAM.
    if (!st_nxt.grant_n) begin
      st_nxt.buf_en = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{cyc: CYC_IDLE, dtack_n: 1'b1, berr_n: 1'b1, viol_n: 1'b1,
                rdata_oe_n: 1'b1, grant_n: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cpu_dtack_n_r     = st_r.dtack_n;
  assign cpu_berr_n_r      = st_r.berr_n;
  assign violation_async_n = st_r.viol_n;
  assign map_rdata_r       = st_r.rdata;
  assign map_rdata_oe_n_r  = st_r.rdata_oe_n;
  assign ram_sel_r         = st_r.ram_sel;
  assign rom_sel_r         = st_r.rom_sel;
  assign io_sel_r          = st_r.io_sel;
  assign ram_buf_en_r      = st_r.buf_en;
  assign phys_addr_r       = st_r.paddr;
  assign disk_grant_n_r    = st_r.grant_n;
  assign cpu_clk_div2      = clks.div2;
  assign phase_clk_div4_n  = clks.div4_n;
  assign clk_div8_n        = clks.div8_n;
  assign clk_div16_n       = clks.div16_n;
  assign stretched_clk_n   = clks.stretched_n;

  a_user_map_io: assert property (@(posedge core_clk) disable iff (!arst_n)
    start && user && sec[1] |=> !st_r.viol_n)
    else $error("User access to map or I/O was not flagged.");

  a_berr_resync: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(st_r.berr_n) |-> !$past(st_r.viol_n))
    else $error("Bus error raised without a prior violation.");

  a_dma_isolate: assert property (@(posedge core_clk) disable iff (!arst_n)
    !st_r.grant_n |-> !st_r.buf_en)
    else $error("RAM buffer enabled during disk ownership.");

  a_grant_cause: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(st_r.grant_n) |-> !$past(bus.dma_req_n) && $past(bus.ras0_n) && $past(bus.ras1_n))
    else $error("Disk grant without request or with a row strobe active.");

  a_grant_phase: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(st_r.grant_n) |-> $past(phase_ok))
    else $error("Disk grant changed off its clock phase.");

  a_fault_berr: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_r.cyc == CYC_LOOKUP && sec == SEC_RAM && user && entry_q[ENT_FAULT]
    |=> !st_r.viol_n ##1 (!st_r.berr_n || bus.as_n))
    else $error("Faulted page access did not raise a bus error.");

  a_remap_rom: assert property (@(posedge core_clk) disable iff (!arst_n)
    start && sec_raw == SEC_RAM && bus.remap |=> st_r.rom_sel && !st_r.ram_sel)
    else $error("Remapped low section did not select ROM.");

  a_page_offset: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(st_r.ram_sel) |-> st_r.paddr[PAGE_LSB-1:1] == $past(offset_bits))
    else $error("Page offset bits were altered by translation.");

  a_wait_no_ack: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_r.cyc == CYC_WAIT_DMA && !st_r.grant_n |=> st_r.dtack_n && !st_r.ram_sel)
    else $error("RAM cycle acknowledged while the disk owns RAM.");

  a_disk_exclusive: assert property (@(posedge core_clk) disable iff (!arst_n)
    !st_r.grant_n |-> !st_r.ram_sel)
    else $error("Disk grant overlaps a processor RAM cycle.");

  a_rom_select: assert property (@(posedge core_clk) disable iff (!arst_n)
    start && sec == SEC_ROM |=> st_r.rom_sel && !st_r.dtack_n)
    else $error("ROM section access did not select the ROM.");

  a_io_user_blocked: assert property (@(posedge core_clk) disable iff (!arst_n)
    start && user && sec == SEC_IO |=> !st_r.io_sel && st_r.dtack_n)
    else $error("User access reached the I/O section.");

  a_super_open: assert property (@(posedge core_clk) disable iff (!arst_n)
    start && !user && sec != SEC_RAM |=> st_r.viol_n)
    else $error("Supervisor access flagged as a violation.");

  a_map_read_data: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_r.cyc == CYC_LOOKUP && sec == SEC_MAP && bus.rd
    |=> !st_r.rdata_oe_n && st_r.rdata == $past(entry_q))
    else $error("Map read did not drive the selected entry.");

  a_wprot_berr: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_r.cyc == CYC_LOOKUP && sec == SEC_RAM && user && entry_q[ENT_WPROT] && !bus.rd
    |=> !st_r.viol_n)
    else $error("Write to a protected page was not flagged.");

endmodule // apm_mapper
`default_nettype wire

// [apm_pkg.sv]
// Shared constants and types of the address decoder and page mapper.
package apm_pkg;

  localparam logic [1:0]  SEC_RAM       = 2'h0;
  localparam logic [1:0]  SEC_ROM       = 2'h1;
  localparam logic [1:0]  SEC_MAP       = 2'h2;
  localparam logic [1:0]  SEC_IO        = 2'h3;
  localparam logic [23:0] MAP_BASE      = 24'h800000;
  localparam int          SEC_MSB       = 23;
  localparam int          SEC_LSB       = 22;
  localparam int          PAGE_LSB      = 11;
  localparam int          PAGE_MSB      = 20;
  localparam int          ENT_FAULT     = 15;
  localparam int          ENT_WPROT     = 14;
  localparam int          ENT_PHYS_MSB  = 11;
  localparam int          NUM_CTX       = 8;
  localparam int          NUM_PAGES     = 1024;
  localparam int          CTX_W         = 3;
  localparam logic [2:0]  CTX_SUPER     = 3'h0;
  localparam logic [1:0]  GRANT_PHASE   = 2'h3;
  localparam logic [3:0]  STRETCH_COUNT = 4'hF;

  typedef struct packed {
    logic [15:0] data;
    logic [23:1] addr;
    logic        as_n;
    logic        uds_n;
    logic        lds_n;
    logic        rd;
    logic        fc2;
    logic        ras0_n;
    logic        ras1_n;
    logic        dma_req_n;
    logic        remap;
    logic        base_clk;
  } apm_pins_t;

  typedef struct packed {
    logic div2;
    logic div4_n;
    logic div8_n;
    logic div16_n;
    logic stretched_n;
    logic [1:0] phase;
  } apm_clks_t;

  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_WAIT_DMA,
    CYC_LOOKUP,
    CYC_ACK,
    CYC_END
  } apm_cyc_t;

endpackage

// [apm_sync.sv]
// Two-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module apm_sync
  import apm_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      arst_n,
  input  wire apm_pins_t pins_in,
  output var  apm_pins_t pins_out
);

  typedef struct packed {
    apm_pins_t s1;
    apm_pins_t s2;
  } apm_sync_st_t;

  apm_sync_st_t st_r;
  apm_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pins_in;
    st_nxt.s2 = st_r.s1;
  end

  // Strobes reset to their idle levels so no cycle is seen after reset.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{s1: '{as_n: 1'b1, uds_n: 1'b1, lds_n: 1'b1, rd: 1'b1, ras0_n: 1'b1,
                      ras1_n: 1'b1, dma_req_n: 1'b1, remap: 1'b1, default: '0},
                s2: '{as_n: 1'b1, uds_n: 1'b1, lds_n: 1'b1, rd: 1'b1, ras0_n: 1'b1,
                      ras1_n: 1'b1, dma_req_n: 1'b1, remap: 1'b1, default: '0}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins_out = st_r.s2;

endmodule // apm_sync
`default_nettype wire
